//--- src/gpp_map.svh
// register offsets, field positions, reset values and widths of the gpio port block
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

`define GPP_ADDR_W 4
`define GPP_A_PA_DATA 4'h0
`define GPP_A_PA_DIR 4'h1
`define GPP_A_PA_PULL 4'h2
`define GPP_A_PA_WAKE 4'h3
`define GPP_A_PB_DATA 4'h4
`define GPP_A_PB_DIR 4'h5
`define GPP_A_PB_PULL 4'h6
`define GPP_A_PULL_STR 4'h7
`define GPP_A_DRIVE 4'h8
`define GPP_A_PORT_A_FUNCTION_SELECT_0 4'h9
`define GPP_A_PORT_A_FUNCTION_SELECT_1 4'ha
`define GPP_A_PORT_B_FUNCTION_SELECT_0 4'hb
`define GPP_A_PORT_B_FUNCTION_SELECT_1 4'hc

`define GPP_PA_W 8
`define GPP_PB_W 5
`define GPP_STR_BIT 0
`define GPP_PORT_A_FUNCTION_SELECT_1_MASK 8'hf3
`define GPP_PORT_B_FUNCTION_SELECT_1_MASK 8'h03
`define GPP_SEL_GPIO 2'h0

`define GPP_RST_DATA 8'hff
`define GPP_RST_DIR 8'hff
`define GPP_RST_PULL 8'h00
`define GPP_RST_WAKE 8'h00
`define GPP_RST_STR 1'h0
`define GPP_RST_DRIVE 8'h00
`define GPP_RST_SEL 8'h00

`endif

//--- src/gpp_pkg.sv
// types shared by the gpio port block
package gpp_pkg;

   typedef enum logic [1:0] {
      GPP_MODE_NORMAL = 2'b00,
      GPP_MODE_IDLE = 2'b01,
      GPP_MODE_SLEEP = 2'b10
   } gpp_mode_e;

   typedef struct packed {
      logic [7:0] pa_dat;
      logic [7:0] pa_dir;
      logic [7:0] pa_pul;
      logic [7:0] pa_wak;
      logic [4:0] pb_dat;
      logic [4:0] pb_dir;
      logic [4:0] pb_pul;
      logic str;
      logic [7:0] drive;
      logic [7:0] port_a_function_select_0;
      logic [7:0] port_a_function_select_1;
      logic [7:0] port_b_function_select_0;
      logic [1:0] port_b_function_select_1;
      logic [7:0] rdata;
      logic wake;
   } gpp_state_s;

   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
   } gpp_sync_s;

endpackage : gpp_pkg

//--- src/gpp_wake_det.sv
// pin synchroniser and falling edge detector for wake-up
`timescale 1ns/1ps
`include "gpp_map.svh"

module gpp_wake_det #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] fall
);
   import gpp_pkg::*;

   gpp_sync_s s_q;
   gpp_sync_s s_d;

   ////////////////////////////////////////////////////////////////////////////
   // s1 feeds only s2; edge logic looks at s2 and s3
   always_comb begin
      s_d = s_q;
      s_d.s1 = 8'(pin_in);
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= '{s1: 8'hff, s2: 8'hff, s3: 8'hff};
      end else begin
         s_q <= s_d;
      end
   end

   // a steady low gives no pulse, only a high to low step
   assign fall = W'(s_q.s3 & ~s_q.s2);

endmodule : gpp_wake_det

//--- src/gpp_port.sv
// gpio ports a and b: registers, pull-high, drive level, function select, wake-up
// Summary of operation
// - pull-high bit 1 enables that pin's pull-high, 0 disables; cleared at reset
// - pull-high acts only while the pin is a digital input function
// - pull strength bit 0 picks weak (0) or strong (1) for all pulls
// - pull strength only matters on pins whose pull-high is enabled
// - pull strength register bits 7 to 1 read as zero
// - a falling edge on an enabled port a pin raises wake-up
// - wake enable bits 7 to 0 map port a pins 7 to 0; cleared at reset
// - wake-up only for gpio inputs while in idle or sleep mode
// - direction bit 1 is input read from pin, 0 is cmos output; reset 1
// - reading an output pin returns its data latch, not the pin level
// - drive level holds four 2-bit fields for port a pin pairs; reset 0
// - output latch holds its value until written again
// - function select fields are two bits; code 00 is plain gpio
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "gpp_map.svh"

module gpp_port #(
   parameter int PA_W = `GPP_PA_W,
   parameter int PB_W = `GPP_PB_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`GPP_ADDR_W-1:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   input wire gpp_pkg::gpp_mode_e lp_mode,
   input wire logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic [7:0] pa_oe_n,
   output logic [7:0] pa_pull_en,
   output logic [7:0] pa_pull_strong,
   output logic [15:0] pa_drive_lvl,
   output logic [15:0] pa_func_sel,
   input wire logic [4:0] pb_in,
   output logic [4:0] pb_out,
   output logic [4:0] pb_oe_n,
   output logic [4:0] pb_pull_en,
   output logic [4:0] pb_pull_strong,
   output logic [9:0] pb_func_sel,
   output logic wake_req
);
   import gpp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decoding shared by both ports

   function automatic logic [7:0] gpp_gpio_mask(input logic [15:0] sel);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         m[i] = (sel[2*i +: 2] == `GPP_SEL_GPIO);
      end
      return m;
   endfunction : gpp_gpio_mask

   function automatic logic [7:0] gpp_rd_pin(input logic [7:0] dir,
                                             input logic [7:0] pin,
                                             input logic [7:0] lat);
      return (dir & pin) | (~dir & lat);
   endfunction : gpp_rd_pin

   localparam gpp_state_s RST_STATE = '{
      pa_dat: `GPP_RST_DATA,
      pa_dir: `GPP_RST_DIR,
      pa_pul: `GPP_RST_PULL,
      pa_wak: `GPP_RST_WAKE,
      pb_dat: 5'h1f,
      pb_dir: 5'h1f,
      pb_pul: 5'h00,
      str: `GPP_RST_STR,
      drive: `GPP_RST_DRIVE,
      port_a_function_select_0: `GPP_RST_SEL,
      port_a_function_select_1: `GPP_RST_SEL,
      port_b_function_select_0: `GPP_RST_SEL,
      port_b_function_select_1: 2'h0,
      rdata: 8'h00,
      wake: 1'b0
   };

   gpp_state_s s_q;
   gpp_state_s s_d;

   logic [15:0] pa_sel;
   logic [15:0] pb_sel;
   logic [7:0] pa_gpio;
   logic [7:0] pb_gpio;
   logic [7:0] pa_fall;
   logic [7:0] wake_hit;
   logic lp_active;

   ////////////////////////////////////////////////////////////////////////////
   // function select fields per pin; pa5 has no field and stays gpio

   assign pa_sel = {s_q.port_a_function_select_1[7:4], `GPP_SEL_GPIO, s_q.port_a_function_select_1[1:0], s_q.port_a_function_select_0};
   assign pb_sel = {6'h00, s_q.port_b_function_select_1, s_q.port_b_function_select_0};
   assign pa_gpio = gpp_gpio_mask(pa_sel);
   assign pb_gpio = gpp_gpio_mask(pb_sel);
   assign pa_func_sel = pa_sel;
   assign pb_func_sel = pb_sel[9:0];

   ////////////////////////////////////////////////////////////////////////////
   // wake-up path

   gpp_wake_det #(
      .W(PA_W)
   ) u_wake (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_in(pa_in),
      .fall(pa_fall)
   );

   assign lp_active = (lp_mode == GPP_MODE_IDLE) || (lp_mode == GPP_MODE_SLEEP);
   // only gpio inputs may wake; a pin driven by the port cannot wake itself
   assign wake_hit = pa_fall & s_q.pa_wak & pa_gpio & s_q.pa_dir;

   ////////////////////////////////////////////////////////////////////////////
   // register file and next state

   always_comb begin
      s_d = s_q;
      s_d.wake = lp_active && (wake_hit != 8'h00);
      if (wr_en) begin
         unique case (addr)
            `GPP_A_PA_DATA: begin
               s_d.pa_dat = wr_data;
            end
            `GPP_A_PA_DIR: begin
               s_d.pa_dir = wr_data;
            end
            `GPP_A_PA_PULL: begin
               s_d.pa_pul = wr_data;
            end
            `GPP_A_PA_WAKE: begin
               s_d.pa_wak = wr_data;
            end
            `GPP_A_PB_DATA: begin
               s_d.pb_dat = wr_data[4:0];
            end
            `GPP_A_PB_DIR: begin
               s_d.pb_dir = wr_data[4:0];
            end
            `GPP_A_PB_PULL: begin
               s_d.pb_pul = wr_data[4:0];
            end
            `GPP_A_PULL_STR: begin
               s_d.str = wr_data[`GPP_STR_BIT];
            end
            `GPP_A_DRIVE: begin
               s_d.drive = wr_data;
            end
            `GPP_A_PORT_A_FUNCTION_SELECT_0: begin
               s_d.port_a_function_select_0 = wr_data;
            end
            `GPP_A_PORT_A_FUNCTION_SELECT_1: begin
               s_d.port_a_function_select_1 = wr_data & `GPP_PORT_A_FUNCTION_SELECT_1_MASK;
            end
            `GPP_A_PORT_B_FUNCTION_SELECT_0: begin
               s_d.port_b_function_select_0 = wr_data;
            end
            `GPP_A_PORT_B_FUNCTION_SELECT_1: begin
               s_d.port_b_function_select_1 = wr_data[1:0];
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
      if (rd_en) begin
         unique case (addr)
            `GPP_A_PA_DATA: begin
               s_d.rdata = gpp_rd_pin(s_q.pa_dir, pa_in, s_q.pa_dat);
            end
            `GPP_A_PA_DIR: begin
               s_d.rdata = s_q.pa_dir;
            end
            `GPP_A_PA_PULL: begin
               s_d.rdata = s_q.pa_pul;
            end
            `GPP_A_PA_WAKE: begin
               s_d.rdata = s_q.pa_wak;
            end
            `GPP_A_PB_DATA: begin
               s_d.rdata = gpp_rd_pin({3'h0, s_q.pb_dir}, {3'h0, pb_in},
                                      {3'h0, s_q.pb_dat});
            end
            `GPP_A_PB_DIR: begin
               s_d.rdata = {3'h0, s_q.pb_dir};
            end
            `GPP_A_PB_PULL: begin
               s_d.rdata = {3'h0, s_q.pb_pul};
            end
            `GPP_A_PULL_STR: begin
               s_d.rdata = {7'h00, s_q.str};
            end
            `GPP_A_DRIVE: begin
               s_d.rdata = s_q.drive;
            end
            `GPP_A_PORT_A_FUNCTION_SELECT_0: begin
               s_d.rdata = s_q.port_a_function_select_0;
            end
            `GPP_A_PORT_A_FUNCTION_SELECT_1: begin
               s_d.rdata = s_q.port_a_function_select_1;
            end
            `GPP_A_PORT_B_FUNCTION_SELECT_0: begin
               s_d.rdata = s_q.port_b_function_select_0;
            end
            `GPP_A_PORT_B_FUNCTION_SELECT_1: begin
               s_d.rdata = {6'h00, s_q.port_b_function_select_1};
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin side outputs

   assign rd_data = s_q.rdata;
   assign wake_req = s_q.wake;
   assign pa_out = s_q.pa_dat;
   assign pb_out = s_q.pb_dat;
   // oe_n low drives the pin; peripheral functions take the pad elsewhere
   assign pa_oe_n = s_q.pa_dir | ~pa_gpio;
   assign pb_oe_n = s_q.pb_dir | ~pb_gpio[4:0];
   // pull only on gpio inputs; cmos outputs never see a pull
   assign pa_pull_en = s_q.pa_pul & s_q.pa_dir & pa_gpio;
   assign pb_pull_en = s_q.pb_pul & s_q.pb_dir & pb_gpio[4:0];
   assign pa_pull_strong = pa_pull_en & {8{s_q.str}};
   assign pb_pull_strong = pb_pull_en & {5{s_q.str}};

   for (genvar g = 0; g < 8; g++) begin : g_drive
      assign pa_drive_lvl[2*g +: 2] = s_q.drive[2*(g/2) +: 2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // judged from the pin side outputs, not from the expression that makes the pull
   a_pull_gated: assert property (
      ((pa_pull_en & ~(gpp_gpio_mask(pa_func_sel) & pa_oe_n)) == 8'h00) &&
      ((pb_pull_en & ~pb_oe_n) == 5'h00)
   ) else $error("pull-high on a pin that is not a gpio input");

   a_strength_off: assert property (
      ((pa_pull_strong & ~pa_pull_en) == 8'h00) &&
      ((pb_pull_strong & ~pb_pull_en) == 5'h00)
   ) else $error("strong pull on a pin without pull-high");

   a_strength_read: assert property (
      rd_en && addr == `GPP_A_PULL_STR |=> rd_data[7:1] == 7'h00 &&
      rd_data[0] == $past(s_q.str)
   ) else $error("pull strength read wrong");

   a_wake_mode: assert property (
      wake_req |-> $past(lp_mode) != GPP_MODE_NORMAL
   ) else $error("wake-up outside low-power mode");

   a_wake_cause: assert property (
      wake_req |-> ($past(pa_fall & s_q.pa_wak & s_q.pa_dir) != 8'h00)
   ) else $error("wake-up without an enabled falling pin");

   a_out_readback: assert property (
      rd_en && addr == `GPP_A_PA_DATA |=>
      ((rd_data ^ $past(s_q.pa_dat)) & ~$past(s_q.pa_dir)) == 8'h00
   ) else $error("output pin read does not show its latch");

   a_latch_hold: assert property (
      !(wr_en && addr == `GPP_A_PA_DATA) |=> $stable(pa_out)
   ) else $error("output latch changed without a write");

   a_pb_upper: assert property (
      rd_en && (addr == `GPP_A_PB_DATA || addr == `GPP_A_PB_DIR ||
      addr == `GPP_A_PB_PULL) |=> rd_data[7:5] == 3'h0
   ) else $error("port b upper bits not zero");

   a_wake_write: assert property (
      wr_en && addr == `GPP_A_PA_WAKE |=> s_q.pa_wak == $past(wr_data)
   ) else $error("wake enable write lost");

   c_wake: cover property (wake_req);
   c_pull_strong: cover property (pa_pull_strong != 8'h00);
   c_read_out: cover property (wr_en && addr == `GPP_A_PA_DIR ##2
                               rd_en && addr == `GPP_A_PA_DATA);

endmodule : gpp_port

//--- bench/gpp_pins.sv
// pad model standing around one gpio port: pin driver, switch and pull-high
`timescale 1ns/1ps
module gpp_pins #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oe_n,
   input wire logic [W-1:0] pull_en,
   input wire logic [W-1:0] ext,
   input wire logic [W-1:0] ext_en,
   output logic [W-1:0] pin
);
   logic [W-1:0] float_q = '0;
   // an undriven pad toggles each cycle so a stale level never passes for a real one
   always @(posedge ref_clk) float_q <= ~float_q;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!oe_n[i]) pin[i] = out[i];
         else if (ext_en[i]) pin[i] = ext[i];
         else if (pull_en[i]) pin[i] = 1'b1;
         else pin[i] = float_q[i];
      end
   end
endmodule : gpp_pins

//--- bench/gpp_port_test.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_port_test;
   import gpp_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, wake_req;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00, rd_data, pa_in, pa_out, pa_oe_n, pa_pull_en, pa_pull_strong;
   logic [7:0] ext_a = 8'h5a, ext_a_en = 8'hff;
   logic [4:0] pb_in, pb_out, pb_oe_n, pb_pull_en, pb_pull_strong, ext_b = 5'h0a;
   logic [4:0] ext_b_en = 5'h1f;
   logic [15:0] pa_drive_lvl, pa_func_sel;
   logic [9:0] pb_func_sel;
   gpp_mode_e lp_mode = GPP_MODE_NORMAL;
   int failures = 0, n_compared = 0, cyc = 0;
   gpp_port gpp_port_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .lp_mode(lp_mode), .pa_in(pa_in),
      .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_pull_en(pa_pull_en),
      .pa_pull_strong(pa_pull_strong), .pa_drive_lvl(pa_drive_lvl), .pa_func_sel(pa_func_sel),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pull_en(pb_pull_en),
      .pb_pull_strong(pb_pull_strong), .pb_func_sel(pb_func_sel), .wake_req(wake_req));
   gpp_pins #(.W(8)) gpp_pins_i (.ref_clk(ref_clk), .out(pa_out), .oe_n(pa_oe_n),
      .pull_en(pa_pull_en), .ext(ext_a), .ext_en(ext_a_en), .pin(pa_in));
   gpp_pins #(.W(5)) gpp_pins_pb_i (.ref_clk(ref_clk), .out(pb_out), .oe_n(pb_oe_n),
      .pull_en(pb_pull_en), .ext(ext_b), .ext_en(ext_b_en), .pin(pb_in));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chkw(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkw
   // bus tasks are entered just after a rising edge and leave one idle cycle behind
   task wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, e);
      @(posedge ref_clk);
   endtask : rd
   task cnt(output logic [7:0] n);
      n = 8'h00;
      repeat (8) begin
         @(negedge ref_clk);
         n = n + {7'h00, wake_req};
      end
      @(posedge ref_clk);
   endtask : cnt
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk(pa_oe_n, 8'hff);
      rd(`GPP_A_PA_DATA, 8'h5a);
      rd(`GPP_A_PA_DIR, 8'hff);
      rd(`GPP_A_PA_PULL, 8'h00);
      rd(`GPP_A_PA_WAKE, 8'h00);
      rd(`GPP_A_PB_DATA, 8'h0a);
      rd(`GPP_A_PB_DIR, 8'h1f);
      rd(`GPP_A_PB_PULL, 8'h00);
      rd(`GPP_A_PULL_STR, 8'h00);
      rd(`GPP_A_DRIVE, 8'h00);
      rd(`GPP_A_PORT_A_FUNCTION_SELECT_1, 8'h00);
      rd(4'hf, 8'h00);
   endtask : t_reset
   task t_latch;
      ext_a <= 8'h0c;
      ext_a_en <= 8'h0f;
      wr(`GPP_A_PA_DATA, 8'h55);
      wr(`GPP_A_PA_DIR, 8'h0f);
      chk(pa_oe_n, 8'h0f);
      chk(pa_out, 8'h55);
      rd(`GPP_A_PA_DATA, 8'h5c);
      wr(`GPP_A_PB_DIR, 8'hfc);
      rd(`GPP_A_PB_DIR, 8'h1c);
      wr(`GPP_A_PB_DATA, 8'hfd);
      chk({3'h0, pb_out}, 8'h1d);
      chk({3'h0, pb_oe_n}, 8'h1c);
      rd(`GPP_A_PB_DATA, 8'h09);
   endtask : t_latch
   task t_pull;
      wr(`GPP_A_PA_DIR, 8'hfe);
      wr(`GPP_A_PA_PULL, 8'hff);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_0, 8'h04);
      chk(pa_pull_en, 8'hfc);
      chk(pa_pull_strong, 8'h00);
      wr(`GPP_A_PULL_STR, 8'hff);
      rd(`GPP_A_PULL_STR, 8'h01);
      chk(pa_pull_strong, 8'hfc);
      wr(`GPP_A_PA_PULL, 8'h0f);
      chk(pa_pull_en, 8'h0c);
      chk(pa_pull_strong, 8'h0c);
      wr(`GPP_A_PB_PULL, 8'hff);
      rd(`GPP_A_PB_PULL, 8'h1f);
      chk({3'h0, pb_pull_en}, 8'h1c);
      chk({3'h0, pb_pull_strong}, 8'h1c);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_0, 8'h00);
      wr(`GPP_A_PA_PULL, 8'h00);
   endtask : t_pull
   task t_sel;
      wr(`GPP_A_DRIVE, 8'he4);
      chkw(pa_drive_lvl, 16'hfa50);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_0, 8'he4);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_1, 8'hff);
      rd(`GPP_A_PORT_A_FUNCTION_SELECT_1, 8'hf3);
      chkw(pa_func_sel, 16'hf3e4);
      wr(`GPP_A_PA_DIR, 8'h00);
      chk(pa_oe_n, 8'hde);
      wr(`GPP_A_PORT_B_FUNCTION_SELECT_0, 8'h1b);
      wr(`GPP_A_PORT_B_FUNCTION_SELECT_1, 8'hff);
      rd(`GPP_A_PORT_B_FUNCTION_SELECT_1, 8'h03);
      chkw({6'h00, pb_func_sel}, 16'h031b);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_0, 8'h00);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_1, 8'h00);
      wr(`GPP_A_PA_DIR, 8'hff);
   endtask : t_sel
   // one falling edge, then a steady low, then the release: exactly e pulses overall
   task wk(input gpp_mode_e m, input int b, input logic [7:0] e);
      logic [7:0] n1, n2;
      lp_mode <= m;
      ext_a[b] <= 1'b0;
      cnt(n1);
      ext_a[b] <= 1'b1;
      cnt(n2);
      chk(n1 + n2, e);
   endtask : wk
   task t_wake;
      ext_a <= 8'hff;
      ext_a_en <= 8'hff;
      wr(`GPP_A_PA_WAKE, 8'h81);
      rd(`GPP_A_PA_WAKE, 8'h81);
      wk(GPP_MODE_NORMAL, 0, 8'h00);
      wk(GPP_MODE_SLEEP, 1, 8'h00);
      wk(GPP_MODE_SLEEP, 0, 8'h01);
      wk(GPP_MODE_IDLE, 7, 8'h01);
      wr(`GPP_A_PA_DIR, 8'h7f);
      wk(GPP_MODE_IDLE, 7, 8'h00);
      wr(`GPP_A_PA_DIR, 8'hff);
      wr(`GPP_A_PORT_A_FUNCTION_SELECT_1, 8'h40);
      wk(GPP_MODE_IDLE, 7, 8'h00);
   endtask : t_wake
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // the whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_latch();
      t_pull();
      t_sel();
      t_wake();
      end_sim();
   end
endmodule : gpp_port_test
